//--- design/tfs_top.sv
// Transmit frame sync direction control with APB registers
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module tfs_top (
    // System clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Backplane link
    input wire logic I_TX_BACKPLANE_SERIAL_CLOCK,
    input wire tfs_pkg::tfs_bound_t I_BOUND_IN,
    output tfs_pkg::tfs_bound_t O_BOUND_OUT,
    output tfs_pkg::tfs_bound_t O_BOUND_OE
);
    import tfs_pkg::*;

    // ==========================================================
    // Decode helpers
    // ==========================================================
    // Recovered line clock encodings
    function automatic logic is_line_clk(input logic [1:0] css);
        is_line_clk = (css == TFS_CSS_LINE_A) || (css == TFS_CSS_LINE_B);
    endfunction

    // Boundary pins are inputs only with serial clock and bit 0
    function automatic logic pins_input(input tfs_cfg_t cfg);
        pins_input = (cfg.css == TFS_CSS_SERCLK) && !cfg.sel;
    endfunction

    // ==========================================================
    // Reset synchronisers
    // ==========================================================
    logic sys_rstn; // System domain reset copy
    logic lnk_rstn; // Link domain reset copy

    // Release of system reset
    tfs_sync2 #(.W(1)) u_sys_rst (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RESETN),
        .i_d(1'b1),
        .o_q(sys_rstn)
    );

    // Release of link reset
    tfs_sync2 #(.W(1)) u_lnk_rst (
        .i_clk(I_TX_BACKPLANE_SERIAL_CLOCK),
        .i_rstn(I_RESETN),
        .i_d(1'b1),
        .o_q(lnk_rstn)
    );

    // ==========================================================
    // APB slave
    // ==========================================================
    logic access; // Access phase seen
    logic commit; // Transfer completes this edge
    logic wr_en; // Write takes effect
    logic hit; // Address is mapped
    logic [31:0] rd_nxt; // Read data for current address
    logic [7:0] smc_r; // Sync mux control register
    logic [1:0] css_r; // Clock source select field
    logic [TFS_CNT_W-1:0] frm_cnt_r; // Frames started
    logic [TFS_CNT_W-1:0] mf_cnt_r; // Multiframes started
    tfs_cfg_t cfg_sys; // Configuration, system domain

    assign access = I_PSEL && I_PENABLE;
    assign commit = access && O_PREADY;
    assign wr_en = commit && I_PWRITE && hit;
    assign cfg_sys.sel = smc_r[TFS_SEL_BIT];
    assign cfg_sys.css = css_r;

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (I_PADDR)
            TFS_ADDR_CLK_SEL: begin
                rd_nxt[1:0] = css_r;
            end
            TFS_ADDR_SYNC_MUX: begin
                rd_nxt[7:0] = smc_r;
            end
            TFS_ADDR_STATUS: begin
                rd_nxt[TFS_ST_INPUT_BIT] = pins_input(cfg_sys);
                rd_nxt[TFS_ST_SERCLK_BIT] = (css_r == TFS_CSS_SERCLK);
                rd_nxt[TFS_ST_LINE_BIT] = is_line_clk(css_r);
            end
            TFS_ADDR_COUNT: begin
                rd_nxt = {mf_cnt_r, frm_cnt_r};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // One wait state, then ready with data and error
    always_ff @(posedge I_CLK_SYS or negedge sys_rstn) begin
        if (!sys_rstn) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= access && !O_PREADY;
            if (access && !O_PREADY) begin
                O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_nxt;
                O_PSLVERR <= !hit;
            end else begin
                O_PRDATA <= 32'h0000_0000;
                O_PSLVERR <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // Sync mux control, reserved bits stay zero
    always_ff @(posedge I_CLK_SYS or negedge sys_rstn) begin
        if (!sys_rstn) begin
            smc_r <= TFS_SMC_RESET;
        end else if (wr_en && I_PADDR == TFS_ADDR_SYNC_MUX) begin
            smc_r <= I_PWDATA[7:0] & TFS_SMC_WMASK;
        end
    end

    // Clock source select field
    always_ff @(posedge I_CLK_SYS or negedge sys_rstn) begin
        if (!sys_rstn) begin
            css_r <= TFS_CSS_RESET;
        end else if (wr_en && I_PADDR == TFS_ADDR_CLK_SEL) begin
            css_r <= I_PWDATA[1:0];
        end
    end

    // ==========================================================
    // Configuration into the link domain
    // ==========================================================
    tfs_cfg_t cfg_lnk; // Configuration, link domain

    // Quasi-static levels pass a plain two-flop chain
    tfs_sync2 #(.W(3)) u_cfg_sync (
        .i_clk(I_TX_BACKPLANE_SERIAL_CLOCK),
        .i_rstn(lnk_rstn),
        .i_d(cfg_sys),
        .o_q(cfg_lnk)
    );

    // ==========================================================
    // Link domain: sampling and boundary generation
    // ==========================================================
    logic lnk_input; // Pins act as inputs
    tfs_bound_t smp_r; // Sampled boundary inputs
    logic [7:0] bit_r; // Bit slot within frame
    logic [4:0] fidx_r; // Frame within multiframe
    logic frm_go; // New frame starts
    logic mf_go; // New multiframe starts
    logic [7:0] bit_nxt; // Next bit slot
    logic [4:0] fidx_nxt; // Next frame index

    assign lnk_input = pins_input(cfg_lnk);

    // Sample boundary pins on the serial clock
    always_ff @(posedge I_TX_BACKPLANE_SERIAL_CLOCK or negedge lnk_rstn) begin
        if (!lnk_rstn) begin
            smp_r <= '0;
        end else if (lnk_input) begin
            smp_r <= I_BOUND_IN;
        end else begin
            smp_r <= '0;
        end
    end

    // Frame start decision per mode
    always_comb begin
        if (lnk_input) begin
            mf_go = smp_r.mframe;
            frm_go = smp_r.frame || smp_r.mframe;
        end else begin
            frm_go = (bit_r == 8'h00);
            mf_go = frm_go && (fidx_r == 5'h00);
        end
    end

    // Bit and frame counters
    always_comb begin
        bit_nxt = bit_r + 8'h01;
        fidx_nxt = fidx_r;
        if (lnk_input && frm_go) begin
            bit_nxt = 8'h01;
            fidx_nxt = mf_go ? 5'h01 : fidx_r + 5'h01;
        end else if (bit_r == TFS_BITS_PER_FRAME - 8'h01) begin
            bit_nxt = 8'h00;
            fidx_nxt = fidx_r + 5'h01;
        end
        if (fidx_nxt == TFS_FRAMES_PER_MF) begin
            fidx_nxt = 5'h00;
        end
    end

    // Counter state
    always_ff @(posedge I_TX_BACKPLANE_SERIAL_CLOCK or negedge lnk_rstn) begin
        if (!lnk_rstn) begin
            bit_r <= 8'h00;
            fidx_r <= 5'h00;
        end else begin
            bit_r <= bit_nxt;
            fidx_r <= fidx_nxt;
        end
    end

    // Pin drivers, released while the system side controls
    always_ff @(posedge I_TX_BACKPLANE_SERIAL_CLOCK or negedge lnk_rstn) begin
        if (!lnk_rstn) begin
            O_BOUND_OUT <= '0;
            O_BOUND_OE <= '0;
        end else if (lnk_input) begin
            O_BOUND_OUT <= '0;
            O_BOUND_OE <= '0;
        end else begin
            O_BOUND_OUT.frame <= frm_go;
            O_BOUND_OUT.mframe <= mf_go;
            O_BOUND_OE <= '1;
        end
    end

    // ==========================================================
    // Boundary events back into the system domain
    // ==========================================================
    logic frm_evt; // Frame started, system domain
    logic mf_evt; // Multiframe started, system domain
    logic cnt_clr; // Software clears counters

    // Frame event crossing
    tfs_evt_xing u_frm_xing (
        .i_src_clk(I_TX_BACKPLANE_SERIAL_CLOCK),
        .i_src_rstn(lnk_rstn),
        .i_src_pulse(frm_go),
        .i_dst_clk(I_CLK_SYS),
        .i_dst_rstn(sys_rstn),
        .o_dst_pulse(frm_evt)
    );

    // Multiframe event crossing
    tfs_evt_xing u_mf_xing (
        .i_src_clk(I_TX_BACKPLANE_SERIAL_CLOCK),
        .i_src_rstn(lnk_rstn),
        .i_src_pulse(mf_go),
        .i_dst_clk(I_CLK_SYS),
        .i_dst_rstn(sys_rstn),
        .o_dst_pulse(mf_evt)
    );

    assign cnt_clr = wr_en && (I_PADDR == TFS_ADDR_COUNT);

    // Frame counter, an event in the clear cycle still counts
    always_ff @(posedge I_CLK_SYS or negedge sys_rstn) begin
        if (!sys_rstn) begin
            frm_cnt_r <= '0;
        end else if (cnt_clr) begin
            frm_cnt_r <= {{(TFS_CNT_W-1){1'b0}}, frm_evt};
        end else if (frm_evt) begin
            frm_cnt_r <= frm_cnt_r + 1'b1;
        end
    end

    // Multiframe counter, same clear policy
    always_ff @(posedge I_CLK_SYS or negedge sys_rstn) begin
        if (!sys_rstn) begin
            mf_cnt_r <= '0;
        end else if (cnt_clr) begin
            mf_cnt_r <= {{(TFS_CNT_W-1){1'b0}}, mf_evt};
        end else if (mf_evt) begin
            mf_cnt_r <= mf_cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- design/tfs_pkg.sv
// Package: constants and carrier types of the transmit frame sync block
package tfs_pkg;
    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [11:0] TFS_ADDR_CLK_SEL = 12'h100; // Clock select
    localparam logic [11:0] TFS_ADDR_SYNC_MUX = 12'h104; // Sync mux control
    localparam logic [11:0] TFS_ADDR_STATUS = 12'h108; // Direction status
    localparam logic [11:0] TFS_ADDR_COUNT = 12'h10c; // Boundary counters
    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int TFS_SEL_BIT = 4; // Frame sync select position
    localparam logic [7:0] TFS_SMC_RESET = 8'h00; // Sync mux reset value
    localparam logic [7:0] TFS_SMC_WMASK = 8'h73; // Writable bits 6,5,4,1,0
    localparam logic [1:0] TFS_CSS_RESET = 2'h0; // Clock select reset value
    localparam int TFS_ST_INPUT_BIT = 0; // Status: pins are inputs
    localparam int TFS_ST_SERCLK_BIT = 1; // Status: serial clock is source
    localparam int TFS_ST_LINE_BIT = 2; // Status: recovered clock is source
    localparam int TFS_CNT_W = 16; // Width of each boundary counter
    // ==========================================================
    // Clock source encodings
    // ==========================================================
    localparam logic [1:0] TFS_CSS_LINE_A = 2'h0; // Recovered line clock
    localparam logic [1:0] TFS_CSS_SERCLK = 2'h1; // Backplane serial clock
    localparam logic [1:0] TFS_CSS_LINE_B = 2'h3; // Recovered line clock
    // ==========================================================
    // Frame timing when the framer drives the boundaries
    // ==========================================================
    localparam logic [7:0] TFS_BITS_PER_FRAME = 8'hc1; // Bit slots per frame
    localparam logic [4:0] TFS_FRAMES_PER_MF = 5'h18; // Frames per multiframe
    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic mframe; // Multiframe boundary
        logic frame; // Frame boundary
    } tfs_bound_t;
    typedef struct packed {
        logic sel; // Frame sync select bit
        logic [1:0] css; // Clock source select
    } tfs_cfg_t;
endpackage

//--- design/tfs_sync2.sv
// Two flip-flop level synchroniser with asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module tfs_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r; // First stage, read only by second
    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- design/tfs_evt_xing.sv
// Toggle based event crossing from source to destination clock
`timescale 1ns/10ps
`default_nettype none
module tfs_evt_xing (
    // Source side
    input wire logic i_src_clk,
    input wire logic i_src_rstn,
    input wire logic i_src_pulse,
    // Destination side
    input wire logic i_dst_clk,
    input wire logic i_dst_rstn,
    output logic o_dst_pulse
);
    logic tog_r; // Source toggle
    logic meta_r; // First sync stage
    logic sync_r; // Second sync stage
    logic last_r; // Previous synced level
    // ==========================================================
    // Source toggle
    // ==========================================================
    always_ff @(posedge i_src_clk or negedge i_src_rstn) begin
        if (!i_src_rstn) begin
            tog_r <= 1'b0;
        end else if (i_src_pulse) begin
            tog_r <= ~tog_r;
        end
    end
    // ==========================================================
    // Destination sync and edge detect
    // ==========================================================
    always_ff @(posedge i_dst_clk or negedge i_dst_rstn) begin
        if (!i_dst_rstn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            o_dst_pulse <= 1'b0;
        end else begin
            meta_r <= tog_r;
            sync_r <= meta_r;
            last_r <= sync_r;
            o_dst_pulse <= sync_r ^ last_r;
        end
    end
endmodule
`default_nettype wire

//--- test/tfs_partner.sv
// System side model driving boundary requests into the framer pins
`timescale 1ns/10ps
`default_nettype none
module tfs_partner (
    // Link clock
    input wire logic i_clk,
    // Bench request and device pin direction
    input wire tfs_pkg::tfs_bound_t i_req,
    input wire tfs_pkg::tfs_bound_t i_dev_oe,
    // Pin drive
    output tfs_pkg::tfs_bound_t o_drv,
    output tfs_pkg::tfs_bound_t o_oe
);
    import tfs_pkg::*;
    // ========
    // Drive
    // ========
    tfs_bound_t drv_r = '0; // Idle low between requests
    // Release the pins whenever the framer drives them
    assign o_oe = ~i_dev_oe;
    // Each request stands for one whole link cycle
    always @(posedge i_clk) begin
        drv_r <= i_req;
    end
    assign o_drv = drv_r;
endmodule
`default_nettype wire

//--- test/tfs_top_properties.sv
// Checker of bus timing and boundary pin behaviour
`timescale 1ns/10ps
`default_nettype none
module tfs_top_props (
    // Clocks and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic I_TX_BACKPLANE_SERIAL_CLOCK,
    // Bus
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // Boundary pins
    input wire tfs_pkg::tfs_bound_t O_BOUND_OUT,
    input wire tfs_pkg::tfs_bound_t O_BOUND_OE
);
    import tfs_pkg::*;
    // ========
    // Frame gap counter
    // ========
    logic [7:0] gap_r; // Link cycles since last frame pulse
    logic gap_ok_r; // A pulse has been seen in this mode
    // Restarts on every pulse, cleared while pins are inputs
    always_ff @(posedge I_TX_BACKPLANE_SERIAL_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            gap_r <= 8'h00;
            gap_ok_r <= 1'b0;
        end else if (!O_BOUND_OE.frame) begin
            gap_r <= 8'h00;
            gap_ok_r <= 1'b0;
        end else if (O_BOUND_OUT.frame) begin
            gap_r <= 8'h00;
            gap_ok_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 8'h01;
        end
    end
    // ========
    // Bus
    // ========
    property p_wait;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY;
    endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait state");
    property p_rdy_one;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN) O_PREADY |=> !O_PREADY;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    property p_err;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN) O_PSLVERR |-> O_PREADY;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rd_idle;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN) !O_PREADY |-> O_PRDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside ready");
    // ========
    // Boundary pins
    // ========
    property p_oe_pair;
        @(posedge I_TX_BACKPLANE_SERIAL_CLOCK) disable iff (!I_RESETN)
        O_BOUND_OE.frame == O_BOUND_OE.mframe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("pin directions differ");
    property p_in_quiet;
        @(posedge I_TX_BACKPLANE_SERIAL_CLOCK) disable iff (!I_RESETN)
        !O_BOUND_OE.frame |-> O_BOUND_OUT == 2'h0;
    endproperty
    a_in_quiet: assert property (p_in_quiet) else $error("output while pins are inputs");
    property p_mf_in_f;
        @(posedge I_TX_BACKPLANE_SERIAL_CLOCK) disable iff (!I_RESETN)
        O_BOUND_OUT.mframe |-> O_BOUND_OUT.frame;
    endproperty
    a_mf_in_f: assert property (p_mf_in_f) else $error("multiframe without frame");
    property p_pulse;
        @(posedge I_TX_BACKPLANE_SERIAL_CLOCK) disable iff (!I_RESETN)
        O_BOUND_OUT.frame |=> !O_BOUND_OUT.frame;
    endproperty
    a_pulse: assert property (p_pulse) else $error("frame pulse too long");
    property p_period;
        @(posedge I_TX_BACKPLANE_SERIAL_CLOCK) disable iff (!I_RESETN)
        O_BOUND_OUT.frame && gap_ok_r |-> gap_r == 8'hc0;
    endproperty
    a_period: assert property (p_period) else $error("frame period wrong");
endmodule
bind tfs_top tfs_top_props u_props (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
    .I_TX_BACKPLANE_SERIAL_CLOCK(I_TX_BACKPLANE_SERIAL_CLOCK),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_BOUND_OUT(O_BOUND_OUT), .O_BOUND_OE(O_BOUND_OE)
);
`default_nettype wire

//--- test/tfs_top_bench.sv
// Self-checking bench of the transmit frame sync block
`timescale 1ns/10ps
`default_nettype none
module tfs_top_bench;
    import tfs_pkg::*;
    // ========
    // Signals
    // ========
    logic clk = 1'b0; // System clock
    logic lclk = 1'b0; // Link clock
    logic rst_n = 1'b0; // Reset, active low
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tfs_bound_t req = '0; // Request to the partner
    tfs_bound_t dout, doe, pdrv, poe;
    logic [1:0] pin; // Resolved pin levels
    int err_total = 0;
    int checked = 0;
    // Clocks unrelated in phase
    always #2 clk = ~clk;
    initial #7 forever #32 lclk = ~lclk;
    // Pin level from both parties
    assign pin = (doe & dout) | (poe & pdrv);
    tfs_top dut (
        .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TX_BACKPLANE_SERIAL_CLOCK(lclk),
        .I_BOUND_IN(tfs_bound_t'(pin)), .O_BOUND_OUT(dout), .O_BOUND_OE(doe)
    );
    tfs_partner u_partner (.i_clk(lclk), .i_req(req), .i_dev_oe(doe), .o_drv(pdrv), .o_oe(poe));
    // ========
    // Tasks
    // ========
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus transfer, waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(nm, e, rd);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    // ========
    // Main sequence
    // ========
    initial begin
        logic [31:0] rd, d;
        logic er;
        int fr, mf, n;
        tfs_bound_t r;
        void'($urandom(32'h7219));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values and unmapped access
        rchk("clk_sel", TFS_ADDR_CLK_SEL, 32'h0);
        rchk("sync_mux", TFS_ADDR_SYNC_MUX, 32'h0);
        rchk("status", TFS_ADDR_STATUS, 32'h4);
        apb(1'b0, 12'h110, 32'h0, rd, er);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        // Every source code with both select values
        for (int i = 0; i < 8; i++) begin
            logic [1:0] css;
            logic sel, inp;
            css = 2'(i >> 1);
            sel = i[0];
            d = ($urandom() & 32'hef) | (32'(sel) << TFS_SEL_BIT);
            wr(TFS_ADDR_CLK_SEL, {30'h0, css});
            wr(TFS_ADDR_SYNC_MUX, d);
            inp = css == 2'h1 && !sel;
            repeat (6) @(posedge lclk);
            @(posedge clk);
            chk("oe", inp ? 32'h0 : 32'h3, {30'h0, doe});
            rchk("sync_mux", TFS_ADDR_SYNC_MUX, d & 32'h73);
            rchk("status", TFS_ADDR_STATUS, {29'h0, css == 2'h0 || css == 2'h3, css == 2'h1, inp});
        end
        // System side requests, back to back
        wr(TFS_ADDR_CLK_SEL, 32'h1);
        wr(TFS_ADDR_SYNC_MUX, 32'h0);
        repeat (6) @(posedge lclk);
        wr(TFS_ADDR_COUNT, 32'h0);
        fr = 0;
        mf = 0;
        for (int k = 0; k < 48; k++) begin
            @(posedge lclk);
            r = tfs_bound_t'($urandom_range(3, 0));
            req <= r;
            fr += (r != 2'h0);
            mf += r.mframe;
        end
        @(posedge lclk);
        req <= '0;
        repeat (6) @(posedge lclk);
        rchk("counts", TFS_ADDR_COUNT, {16'(mf), 16'(fr)});
        // Framer driven timing: model counts one multiframe of pulses
        wr(TFS_ADDR_SYNC_MUX, 32'h10);
        n = 0;
        do begin
            @(posedge lclk);
            n++;
        end while (dout.frame !== 1'b1 && n < 400);
        if (n >= 400) begin
            err_total++;
            wrap_up();
        end
        // Clear well away from a pulse so none is in flight
        repeat (6) @(posedge lclk);
        wr(TFS_ADDR_COUNT, 32'h0);
        fr = 0;
        mf = 0;
        n = 0;
        while (fr < int'(TFS_FRAMES_PER_MF) && n < 5000) begin
            @(posedge lclk);
            n++;
            fr += dout.frame;
            mf += dout.mframe;
        end
        if (n >= 5000) begin
            err_total++;
            wrap_up();
        end
        repeat (6) @(posedge lclk);
        rchk("out_counts", TFS_ADDR_COUNT, {16'(mf), 16'(fr)});
        chk("mf_per_mframe", 32'h1, 32'(mf));
        chk("oe_drive", 32'h3, {30'h0, doe});
        wrap_up();
    end
endmodule
`default_nettype wire
